// File: shared/dscr_cfg.svh
// offsets, field positions and counts of the dac serial register bank
// assumes inclusion by bare name from the package and the core
`ifndef DSCR_CFG_SVH
`define DSCR_CFG_SVH
`define DSCR_A_COMM   5'h00
`define DSCR_A_DATA   5'h02
`define DSCR_A_REV    5'h0d
`define DSCR_A_CAL    5'h0e
`define DSCR_A_MEM    5'h0f
`define DSCR_A_PTR    5'h10
`define DSCR_A_WORD   5'h11
`define DSCR_B_DIR    7
`define DSCR_B_ORDER  6
`define DSCR_B_SRST   5
`define DSCR_B_SLEEP  4
`define DSCR_B_PDN    3
`define DSCR_B_RESYNC 1
`define DSCR_B_SCRUN  6
`define DSCR_B_FCRUN  4
`define DSCR_B_SWR    3
`define DSCR_B_SRD    2
`define DSCR_B_FRD    1
`define DSCR_B_RD     7
// arbitrary neutral hardware version value
`define DSCR_HW_REV   4'h1
`define DSCR_DIV_BASE 13'h0020
`define DSCR_WORD_W   6
`define DSCR_STORE_N  256
`endif

// File: shared/dscr_pkg.sv
// types shared by the dac serial register bank
// assumes the cfg header sits beside it
package dscr_pkg;
  `include "dscr_cfg.svh"
  typedef enum logic [1:0] {
    DSCR_IDLE, DSCR_INSTR, DSCR_DATA, DSCR_WAIT
  } dscr_state_e;
  typedef logic [`DSCR_WORD_W-1:0] dscr_word_t;
endpackage

// File: core/dscr_regs.sv
// serial control register bank of the lvds dac, with calibration store
// assumes slow serial pins sampled at 20 mhz and core logic on clock
`include "dscr_cfg.svh"
// Behaviour
// [R1] bit 7 lets data pin drive reads
// [R2] bit 6 picks lsb or msb first
// [R3] soft reset defaults all but address 00
// [R4] sleep bit turns dac current off
// [R5] power down all but serial port
// [R6] host writes reserved zero, ignores reads
// [R7] format bit selects unsigned or twos complement
// [R8] rate bit selects single or double rate
// [R9] input clock edge select bit
// [R10] output clock edge select bit
// [R11] manual mode waits for host resync
// [R12] host sets resync, reads zero when done
// [R13] read-only flag shows resync needed
// [R14] version register returns four-bit id
// [R15] two-bit calibration source select field
// [R16] divider code sets calibration clock ratio
// [R17] selfcal run bit and done status
// [R18] factory copy run bit and done status
// [R19] static write stores word at pointer
// [R20] static or factory read into word
// [R21] pointer and word registers reset zero
// [R22] disable pin stops port, ddr pin rules
// [R23] disabled port: clock pin requests resync
// [R24] auto resync may lose two words
// [R25] hardware reset starts synchronisation
// [R26] middle divider codes keep doubling
// [R27] resync bit clears itself when done
module dscr_regs import dscr_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // serial port pins
  input  wire logic       sclk_pin,
  input  wire logic       csb_n_pin,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  output logic            sdo_out,
  // strap pins
  input  wire logic       port_disable_pin,
  input  wire logic       ddr_pin,
  // core controls
  output logic            dac_current_off,
  output logic            power_down,
  output logic            ext_ref_select,
  output logic            sample_number_format,
  output logic            ddr_mode,
  output logic            input_clock_edge_select,
  output logic            output_clock_edge_select,
  output logic            outgoing_clock_disable,
  // synchroniser handshake
  output logic            sync_start,
  input  wire logic       sync_done,
  input  wire logic       sync_alarm,
  // calibration
  output logic [1:0]      cal_source_select,
  output logic            use_uncalibrated,
  output logic            cal_tick,
  output logic            selfcal_start,
  input  wire logic       selfcal_finished,
  output logic            factory_copy_start,
  input  wire logic       factory_copy_finished,
  output logic [7:0]      cal_memory_pointer,
  input  wire dscr_word_t factory_word,
  input  wire logic       selfcal_wr_en,
  input  wire logic [7:0] selfcal_wr_addr,
  input  wire dscr_word_t selfcal_wr_data
);
  // pin synchroniser, order: sclk csb sdio dis ddr
  logic [4:0]  meta_r;           // first stage, read only by sync_r
  logic [4:0]  sync_r;           // second stage
  logic        sclk_q_r;         // previous synced sclk
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // chip select idles high, so reset must not fake a frame
      meta_r   <= 5'h08;
      sync_r   <= 5'h08;
      sclk_q_r <= 1'b0;
    end else begin
      meta_r   <= {sclk_pin, csb_n_pin, sdio_in, port_disable_pin,
                   ddr_pin};
      sync_r   <= meta_r;
      sclk_q_r <= sync_r[4];
    end
  end
  wire sclk_s   = sync_r[4];
  wire csb_s    = sync_r[3];
  wire sdi_s    = sync_r[2];
  wire port_dis = sync_r[1];
  wire ddr_s    = sync_r[0];
  wire sclk_up  = sclk_s & ~sclk_q_r;
  wire sclk_dn  = ~sclk_s & sclk_q_r;

  // register fields
  logic       dir_r, order_r, sleep_r, pdn_r, xref_r;
  logic [7:3] dctl_r;            // format, rate, edges, clock disable
  logic       manual_r;          // manual resync mode
  logic       resync_r;          // resync request bit
  logic [1:0] src_r;
  logic [2:0] div_r;
  logic       sc_run_r, sc_done_r, fc_run_r, fc_done_r, uncal_r;
  logic [7:0] ptr_r;
  dscr_word_t word_r;
  dscr_word_t store [`DSCR_STORE_N];  // static calibration store

  // serial engine state
  dscr_state_e st_r;
  logic [2:0]  cnt_r;
  logic [7:0]  rx_r, tx_r;
  logic        lsb_r;            // bit order frozen per transfer
  logic        rd_r;
  logic [4:0]  addr_r;
  logic        wr_en_r;
  logic [4:0]  wr_addr_r;
  logic [7:0]  wr_data_r;

  // shift helpers follow the frozen bit order
  wire [7:0] rx_nxt = lsb_r ? {sdi_s, rx_r[7:1]} : {rx_r[6:0], sdi_s};
  wire [7:0] tx_nxt = lsb_r ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
  wire       tx_bit = lsb_r ? tx_r[0] : tx_r[7];

  // read mux, reserved bits read zero
  logic [7:0] rdata;
  wire [7:0] r_comm = {dir_r, order_r, 1'b0, sleep_r, pdn_r, 2'b00,
                       xref_r};
  wire [7:0] r_data = {dctl_r, manual_r, resync_r, sync_alarm};  // R13
  wire [7:0] r_cal  = {2'b00, src_r, 1'b0, div_r};
  wire [7:0] r_mem  = {sc_done_r, sc_run_r, fc_done_r, fc_run_r, 3'b000,
                       uncal_r};
  always_comb begin
    unique case (rx_nxt[4:0])
      `DSCR_A_COMM: rdata = r_comm;
      `DSCR_A_DATA: rdata = r_data;
      `DSCR_A_REV:  rdata = {4'h0, `DSCR_HW_REV};  // R14
      `DSCR_A_CAL:  rdata = r_cal;
      `DSCR_A_MEM:  rdata = r_mem;
      `DSCR_A_PTR:  rdata = ptr_r;
      `DSCR_A_WORD: rdata = {2'b00, word_r};
      default:      rdata = 8'h00;
    endcase
  end

  // serial transfer: instruction byte then one data byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= DSCR_IDLE;
      cnt_r <= 3'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      lsb_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 5'h00;
      wr_en_r <= 1'b0;
      wr_addr_r <= 5'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (csb_s || port_dis) begin  // R22
        st_r  <= DSCR_IDLE;
        cnt_r <= 3'h0;
      end else begin
        unique case (st_r)
          DSCR_IDLE: begin
            st_r  <= DSCR_INSTR;
            lsb_r <= order_r;  // R2
          end
          DSCR_INSTR: if (sclk_up) begin
            rx_r  <= rx_nxt;
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              st_r   <= DSCR_DATA;
              rd_r   <= rx_nxt[`DSCR_B_RD];
              addr_r <= rx_nxt[4:0];
              tx_r   <= rdata;
            end
          end
          DSCR_DATA: begin
            if (sclk_dn && rd_r && cnt_r != 3'h0)
              tx_r <= tx_nxt;
            if (sclk_up) begin
              rx_r  <= rx_nxt;
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == 3'h7) begin
                st_r      <= DSCR_WAIT;
                wr_en_r   <= ~rd_r;
                wr_addr_r <= addr_r;
                wr_data_r <= rx_nxt;
              end
            end
          end
          DSCR_WAIT: st_r <= DSCR_WAIT;  // hold until csb rises
        endcase
      end
    end
  end

  // read data pin steering
  wire reading = (st_r == DSCR_DATA) && rd_r && !csb_s && !port_dis;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
      sdo_out  <= 1'b0;
    end else begin
      sdio_out <= tx_bit;
      sdio_oe  <= reading && dir_r;  // R1
      // disabled port turns sdo into the alarm pin
      sdo_out  <= port_dis ? sync_alarm : (tx_bit & reading);
    end
  end

  // write decode
  wire w_comm = wr_en_r && wr_addr_r == `DSCR_A_COMM;
  wire w_data = wr_en_r && wr_addr_r == `DSCR_A_DATA;
  wire w_cal  = wr_en_r && wr_addr_r == `DSCR_A_CAL;
  wire w_mem  = wr_en_r && wr_addr_r == `DSCR_A_MEM;
  wire w_ptr  = wr_en_r && wr_addr_r == `DSCR_A_PTR;
  wire w_word = wr_en_r && wr_addr_r == `DSCR_A_WORD;
  wire srst   = w_comm && wr_data_r[`DSCR_B_SRST];  // R3

  // comm control skips soft reset defaults and loads the other bits of the same write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {dir_r, order_r, sleep_r, pdn_r, xref_r} <= 5'h00;
    end else if (w_comm) begin
      dir_r   <= wr_data_r[`DSCR_B_DIR];    // R1
      order_r <= wr_data_r[`DSCR_B_ORDER];  // R2
      sleep_r <= wr_data_r[`DSCR_B_SLEEP];  // R4
      pdn_r   <= wr_data_r[`DSCR_B_PDN];    // R5
      xref_r  <= wr_data_r[0];
    end
  end

  // resync triggers: host bit, disabled-port clock pin, auto alarm, boot
  logic boot_r;   // high for the first cycle after reset release
  logic alarm_q_r;
  wire host_sync = w_data && wr_data_r[`DSCR_B_RESYNC];   // R12
  wire pin_sync  = port_dis && sclk_up;                   // R23
  // auto mode may drop or repeat two words; accepted
  wire auto_sync = !manual_r && sync_alarm && !alarm_q_r; // R11 R24
  wire sync_req  = host_sync || pin_sync || auto_sync || boot_r;  // R25
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_r    <= 1'b1;
      alarm_q_r <= 1'b0;
      resync_r  <= 1'b0;
      dctl_r    <= 5'h00;
      manual_r  <= 1'b0;
    end else begin
      boot_r    <= 1'b0;
      alarm_q_r <= sync_alarm;
      // set wins over the self clear
      if (sync_req && !pdn_r)
        resync_r <= 1'b1;
      else if (sync_done || srst)
        resync_r <= 1'b0;  // R27
      if (srst) begin
        dctl_r   <= 5'h00;
        manual_r <= 1'b0;
      end else if (w_data) begin
        dctl_r   <= wr_data_r[7:3];  // R7 R8 R9 R10
        manual_r <= wr_data_r[2];    // R11
      end
    end
  end

  // calibration setup, run bits and status
  wire sc_go = w_mem && wr_data_r[`DSCR_B_SCRUN] && !pdn_r;
  wire fc_go = w_mem && wr_data_r[`DSCR_B_FCRUN] && !pdn_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= 2'b00;
      div_r <= 3'h0;
      {sc_run_r, sc_done_r, fc_run_r, fc_done_r, uncal_r} <= 5'h00;
    end else if (srst) begin
      src_r <= 2'b00;
      div_r <= 3'h0;
      {sc_run_r, sc_done_r, fc_run_r, fc_done_r, uncal_r} <= 5'h00;
    end else begin
      if (w_cal) begin
        src_r <= wr_data_r[5:4];  // R15
        div_r <= wr_data_r[2:0];  // R16
      end
      if (w_mem)
        uncal_r <= wr_data_r[0];
      // finish sets done; a fresh start in the same cycle wins
      if (sc_go) begin
        sc_run_r  <= 1'b1;  // R17
        sc_done_r <= 1'b0;
      end else if (selfcal_finished && sc_run_r) begin
        sc_run_r  <= 1'b0;
        sc_done_r <= 1'b1;
      end
      if (fc_go) begin
        fc_run_r  <= 1'b1;  // R18
        fc_done_r <= 1'b0;
      end else if (factory_copy_finished && fc_run_r) begin
        fc_run_r  <= 1'b0;
        fc_done_r <= 1'b1;
      end
    end
  end

  // pointer, word and static store access
  wire s_wr = w_mem && wr_data_r[`DSCR_B_SWR];
  wire s_rd = w_mem && wr_data_r[`DSCR_B_SRD];
  wire f_rd = w_mem && wr_data_r[`DSCR_B_FRD];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r  <= 8'h00;  // R21
      word_r <= '0;
    end else if (srst) begin
      ptr_r  <= 8'h00;
      word_r <= '0;
    end else begin
      if (w_ptr)
        ptr_r <= wr_data_r;
      if (w_word)
        word_r <= wr_data_r[5:0];
      else if (s_rd)
        word_r <= store[ptr_r];  // R20
      else if (f_rd)
        word_r <= factory_word;  // R20
    end
  end
  // store has no reset; host write beats the calibration engine
  always_ff @(posedge clock) begin
    if (s_wr)
      store[ptr_r] <= word_r;  // R19
    else if (selfcal_wr_en)
      store[selfcal_wr_addr] <= selfcal_wr_data;
  end

  // calibration clock divider, ratio 32 doubled per code
  logic [11:0] div_cnt_r;
  wire [12:0] ratio = `DSCR_DIV_BASE << div_r;  // R16 R26
  wire [11:0] last  = 12'(ratio - 13'h0001);
  wire        tick  = sc_run_r && !pdn_r && div_cnt_r == last;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      div_cnt_r <= 12'h000;
    else if (!sc_run_r || pdn_r || tick)
      div_cnt_r <= 12'h000;
    else
      div_cnt_r <= div_cnt_r + 12'h001;
  end

  // registered core outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dac_current_off <= 1'b0;
      power_down <= 1'b0;
      ext_ref_select <= 1'b0;
      sample_number_format <= 1'b0;
      ddr_mode <= 1'b0;
      input_clock_edge_select <= 1'b0;
      output_clock_edge_select <= 1'b0;
      outgoing_clock_disable <= 1'b0;
      sync_start <= 1'b0;
      cal_source_select <= 2'b00;
      use_uncalibrated <= 1'b0;
      cal_tick <= 1'b0;
      selfcal_start <= 1'b0;
      factory_copy_start <= 1'b0;
      cal_memory_pointer <= 8'h00;
    end else begin
      dac_current_off <= sleep_r || pdn_r;  // R4 R5
      power_down <= pdn_r;                  // R5
      ext_ref_select <= xref_r;
      sample_number_format <= dctl_r[7];    // R7
      ddr_mode <= port_dis ? ddr_s : dctl_r[6];  // R8 R22
      input_clock_edge_select <= dctl_r[5];   // R9
      output_clock_edge_select <= dctl_r[4];  // R10
      outgoing_clock_disable <= dctl_r[3];
      sync_start <= sync_req && !pdn_r;     // R12 R25
      cal_source_select <= src_r;           // R15
      use_uncalibrated <= uncal_r;
      cal_tick <= tick;                     // R16
      selfcal_start <= sc_go;               // R17
      factory_copy_start <= fc_go;          // R18
      cal_memory_pointer <= ptr_r;          // R21
    end
  end

  // checks
  sequence s_host_resync;
    w_data && wr_data_r[`DSCR_B_RESYNC] && !pdn_r;
  endsequence
  sequence s_soft_reset;
    w_comm && wr_data_r[`DSCR_B_SRST];
  endsequence
  chk_host_resync_start: assert property (  // R12
    @(posedge clock) disable iff (!rst_n)
    s_host_resync |=> sync_start ##0 resync_r)
    else $error("resync write gave no start");
  chk_resync_self_clear: assert property (  // R27
    @(posedge clock) disable iff (!rst_n)
    sync_done && !sync_req |=> !resync_r)
    else $error("resync bit did not clear");
  chk_soft_reset_dflt: assert property (  // R3
    @(posedge clock) disable iff (!rst_n)
    s_soft_reset |=> ptr_r == 8'h00 && dctl_r == 5'h00 && !sc_run_r
      && dir_r == $past(wr_data_r[`DSCR_B_DIR]))
    else $error("soft reset defaults wrong");
  chk_sleep_current: assert property (  // R4
    @(posedge clock) disable iff (!rst_n)
    sleep_r && $stable(sleep_r) |=> dac_current_off)
    else $error("sleep left current on");
  chk_pdn_no_start: assert property (  // R5
    @(posedge clock) disable iff (!rst_n)
    pdn_r |=> !selfcal_start && !factory_copy_start && !sync_start)
    else $error("start issued in power down");
  chk_ddr_pin_take: assert property (  // R22
    @(posedge clock) disable iff (!rst_n)
    port_dis |=> ddr_mode == $past(ddr_s))
    else $error("ddr pin not followed");
  chk_sdio_dir_hold: assert property (  // R1
    @(posedge clock) disable iff (!rst_n)
    !dir_r [*2] |-> !sdio_oe)
    else $error("sdio driven in input mode");
  chk_div_spacing: assert property (  // R16
    @(posedge clock) disable iff (!rst_n)
    cal_tick |=> !cal_tick [*8])
    else $error("cal tick too frequent");
  chk_selfcal_status: assert property (  // R17
    @(posedge clock) disable iff (!rst_n)
    sc_run_r && selfcal_finished && !sc_go |=> sc_done_r && !sc_run_r)
    else $error("selfcal status not updated");
  chk_boot_sync: assert property (  // R25
    @(posedge clock) disable iff (!rst_n)
    boot_r |=> sync_start)
    else $error("no sync after reset");
endmodule

// File: testbench/dscr_core_model.sv
// stand-in for the synchroniser and calibration engine behind the bank
// assumes start pulses on clock; the bench sets the answer delay
module dscr_core_model import dscr_pkg::*; (
  // clock
  input  wire logic       clock,
  // job requests from the bank
  input  wire logic       sync_start,
  input  wire logic       selfcal_start,
  input  wire logic       factory_copy_start,
  input  wire logic [7:0] cal_memory_pointer,
  // answers
  output logic            sync_done,
  output logic            selfcal_finished,
  output logic            factory_copy_finished,
  output dscr_word_t      factory_word
);
  timeunit 1ns;
  timeprecision 1ns;
  int delay = 20; // cycles each job runs, slow or prompt
  int sy_n  = 0;  // cycles left of a resync
  int sc_n  = 0;  // cycles left of a self calibration
  int fc_n  = 0;  // cycles left of a factory copy
  // one-cycle finish pulses as each count hits one
  assign sync_done = (sy_n == 1);
  assign selfcal_finished = (sc_n == 1);
  assign factory_copy_finished = (fc_n == 1);
  // factory store content: inverse of the pointer, so reads differ
  assign factory_word = ~cal_memory_pointer[5:0];
  // a new start restarts the job count
  always @(posedge clock) begin
    sy_n <= sync_start ? delay : (sy_n > 0 ? sy_n - 1 : 0);
    sc_n <= selfcal_start ? delay : (sc_n > 0 ? sc_n - 1 : 0);
    fc_n <= factory_copy_start ? delay : (fc_n > 0 ? fc_n - 1 : 0);
  end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the dac serial register bank
// assumes the core responder model and the cfg header beside it
`include "dscr_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // pins the bench drives
  logic clock, rst_n, sclk_pin, csb_n_pin, tb_sdio;
  logic port_disable_pin, ddr_pin, sync_alarm;
  logic lsb, dir; // bit order and pin mode the bank now holds
  // bank outputs and shared wires
  wire sdio_in, sdio_out, sdio_oe, sdo_out, dac_current_off, power_down;
  wire ext_ref_select, sample_number_format, ddr_mode;
  wire input_clock_edge_select, output_clock_edge_select;
  wire outgoing_clock_disable, sync_start, sync_done, use_uncalibrated;
  wire cal_tick, selfcal_start, selfcal_finished, factory_copy_start;
  wire factory_copy_finished;
  wire [1:0] cal_source_select;
  wire [7:0] cal_memory_pointer;
  wire [5:0] factory_word;
  int err_count = 0;  // mismatches
  int n_compared = 0; // comparisons
  int ns = 0;         // sync start pulses seen
  int nt = 0;         // calibration ticks seen
  int d;              // tick spacing in cycles
  time t0, t1;        // last two tick times
  // data wire level: the bank wins only while it drives
  assign sdio_in = sdio_oe ? sdio_out : tb_sdio;
  // engine write port left idle; only host store writes are exercised
  dscr_regs dut_u (.clock, .rst_n, .sclk_pin, .csb_n_pin, .sdio_in,
    .sdio_out, .sdio_oe, .sdo_out, .port_disable_pin, .ddr_pin,
    .dac_current_off, .power_down, .ext_ref_select, .sample_number_format,
    .ddr_mode, .input_clock_edge_select, .output_clock_edge_select,
    .outgoing_clock_disable, .sync_start, .sync_done, .sync_alarm,
    .cal_source_select, .use_uncalibrated, .cal_tick, .selfcal_start,
    .selfcal_finished, .factory_copy_start, .factory_copy_finished,
    .cal_memory_pointer, .factory_word, .selfcal_wr_en(1'b0),
    .selfcal_wr_addr(8'h00), .selfcal_wr_data(6'h00));
  dscr_core_model core_u (.clock, .sync_start, .selfcal_start,
    .factory_copy_start, .cal_memory_pointer, .sync_done,
    .selfcal_finished, .factory_copy_finished, .factory_word);
  // 50 ns clock
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // count start pulses and time the calibration ticks
  always @(posedge clock) begin
    if (sync_start === 1'b1) ns++;
    if (cal_tick === 1'b1) begin
      nt++;
      t0 = t1;
      t1 = $time;
    end
  end
  task check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // wait n edges, then step just past the edge
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one framed transfer; half periods of 6 clocks beat the pin sync
  task xfer(input logic rd, input logic [4:0] a, input logic [7:0] wd,
            output logic [7:0] q);
    logic [15:0] w;
    int k;
    w = {rd, 2'b00, a, wd};
    q = 8'h00;
    csb_n_pin = 0;
    cyc(6);
    for (int i = 0; i < 16; i++) begin
      k = lsb ? (i < 8 ? 8 + i : i - 8) : 15 - i;
      // released data line toggles so a stale bit cannot pass
      tb_sdio = (rd && i > 7) ? ~tb_sdio : w[k];
      sclk_pin = 0;
      cyc(6);
      if (rd && i > 7) begin
        check(8'(sdio_oe), 8'(dir));
        q[k] = dir ? sdio_in : sdo_out;
      end
      sclk_pin = 1;
      cyc(6);
    end
    sclk_pin = 0;
    cyc(6);
    csb_n_pin = 1;
    cyc(6);
  endtask
  // write; mode bits of the control register count from the next frame
  task wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] q;
    xfer(1'b0, a, v, q);
    if (a == `DSCR_A_COMM) begin
      lsb = v[6];
      dir = v[7];
    end
  endtask
  // read and compare with reserved bits masked off
  task rdc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b1, a, 8'h00, q);
    check(q & m, e);
  endtask
  task print_verdict;
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well past the expected run length
  initial begin
    #(90000 * 50);
    err_count++;
    $display("watchdog expired");
    print_verdict;
  end
  initial begin
    {rst_n, sclk_pin, tb_sdio, port_disable_pin, ddr_pin} = 0;
    {sync_alarm, lsb, dir} = 0;
    csb_n_pin = 1;
    cyc(12);
    rst_n = 1;
    cyc(6);
    check(8'(ns), 8'h01);
    rdc(`DSCR_A_COMM, 8'hf9, 8'h00);
    rdc(`DSCR_A_DATA, 8'hff, 8'h00);
    rdc(`DSCR_A_REV, 8'h0f, {4'h0, `DSCR_HW_REV});
    rdc(`DSCR_A_CAL, 8'h37, 8'h00);
    rdc(`DSCR_A_PTR, 8'hff, 8'h00);
    rdc(`DSCR_A_WORD, 8'h3f, 8'h00);
    rdc(5'h05, 8'hff, 8'h00);
    $display("test reset values done");
    // walk a one through the data path fields
    for (int b = 3; b < 8; b++) begin
      wr(`DSCR_A_DATA, 8'h01 << b);
      check({3'h0, sample_number_format, ddr_mode, input_clock_edge_select,
        output_clock_edge_select, outgoing_clock_disable},
        8'h01 << (b - 3));
    end
    ns = 0;
    sync_alarm = 1;
    rdc(`DSCR_A_DATA, 8'h01, 8'h01);
    check(8'(ns), 8'h01);
    sync_alarm = 0;
    $display("test data path done");
    // slow synchroniser: request stays visible until it answers
    core_u.delay = 1000;
    ns = 0;
    wr(`DSCR_A_DATA, 8'h02);
    rdc(`DSCR_A_DATA, 8'h02, 8'h02);
    cyc(1000);
    rdc(`DSCR_A_DATA, 8'h02, 8'h00);
    check(8'(ns), 8'h01);
    $display("test resync done");
    wr(`DSCR_A_COMM, 8'h18);
    check({6'h0, dac_current_off, power_down}, 8'h03);
    rdc(`DSCR_A_COMM, 8'hf9, 8'h18);
    wr(`DSCR_A_COMM, 8'h01);
    check({5'h0, dac_current_off, power_down, ext_ref_select}, 8'h01);
    $display("test power modes done");
    wr(`DSCR_A_PTR, 8'ha5);
    wr(`DSCR_A_CAL, 8'h35);
    wr(`DSCR_A_DATA, 8'h80);
    wr(`DSCR_A_COMM, 8'h21);
    rdc(`DSCR_A_COMM, 8'hf9, 8'h01);
    rdc(`DSCR_A_PTR, 8'hff, 8'h00);
    rdc(`DSCR_A_CAL, 8'h37, 8'h00);
    rdc(`DSCR_A_DATA, 8'hfd, 8'h00);
    $display("test soft reset done");
    // every divider code, timed over a running self calibration
    for (int c = 0; c < 8; c++) begin
      wr(`DSCR_A_CAL, {2'b00, 2'(c), 1'b0, 3'(c)});
      check({6'h0, cal_source_select}, 8'(c % 4));
      // one spare period so the run bit is still up after three ticks
      core_u.delay = 4 * (32 << c);
      nt = 0;
      wr(`DSCR_A_MEM, 8'h40);
      for (int w = 0; w < 20000 && nt < 3; w++) cyc(1);
      d = int'((t1 - t0) / 50);
      check(8'(d), 8'(32 << c));
      check(8'(d >> 8), 8'((32 << c) >> 8));
      if (c == 7) rdc(`DSCR_A_MEM, 8'hc0, 8'h40);
      cyc(32 << c);
      rdc(`DSCR_A_MEM, 8'hc0, 8'h80);
    end
    $display("test calibration clock done");
    core_u.delay = 600;
    wr(`DSCR_A_MEM, 8'h10);
    rdc(`DSCR_A_MEM, 8'h30, 8'h10);
    cyc(600);
    rdc(`DSCR_A_MEM, 8'h30, 8'h20);
    $display("test factory copy done");
    wr(`DSCR_A_PTR, 8'h3c);
    check(cal_memory_pointer, 8'h3c);
    wr(`DSCR_A_WORD, 8'h2a);
    wr(`DSCR_A_MEM, 8'h08);
    wr(`DSCR_A_WORD, 8'h00);
    wr(`DSCR_A_MEM, 8'h04);
    rdc(`DSCR_A_WORD, 8'h3f, 8'h2a);
    wr(`DSCR_A_MEM, 8'h02);
    rdc(`DSCR_A_WORD, 8'h3f, 8'h03);
    wr(`DSCR_A_MEM, 8'h01);
    check(8'(use_uncalibrated), 8'h01);
    rdc(`DSCR_A_MEM, 8'h01, 8'h01);
    $display("test calibration store done");
    // least significant first, read back over the shared data pin
    wr(`DSCR_A_COMM, 8'hc0);
    wr(`DSCR_A_PTR, 8'h12);
    check(cal_memory_pointer, 8'h12);
    rdc(`DSCR_A_PTR, 8'hff, 8'h12);
    wr(`DSCR_A_COMM, 8'h00);
    rdc(`DSCR_A_PTR, 8'hff, 8'h12);
    $display("test bit order done");
    // manual mode: a raised alarm alone starts nothing
    wr(`DSCR_A_DATA, 8'h04);
    // port disabled: pins take over, serial writes are dropped
    sync_alarm = 1;
    port_disable_pin = 1;
    ddr_pin = 1;
    ns = 0;
    cyc(6);
    check({6'h0, ddr_mode, sdo_out}, 8'h03);
    check(8'(ns), 8'h00);
    sclk_pin = 1;
    cyc(6);
    sclk_pin = 0;
    cyc(6);
    check(8'(ns), 8'h01);
    wr(`DSCR_A_PTR, 8'h77);
    ddr_pin = 0;
    cyc(6);
    check(8'(ddr_mode), 8'h00);
    port_disable_pin = 0;
    sync_alarm = 0;
    cyc(1200);
    rdc(`DSCR_A_PTR, 8'hff, 8'h12);
    $display("test port disable done");
    print_verdict;
  end
endmodule
